// ---- hdl/acc_overflow.v ----
// guard-bit and range overflow detection for one 40-bit accumulator result
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
module acc_overflow (
  // adder output
  input wire [39:0] accSum,
  input wire carry39Lost,
  input wire superSel,
  // flags
  output wire guardOverflow,
  output wire clipEvent
);
  // guard bits 39..31 must all equal each other, else the value left 1.31 range
  assign guardOverflow = ~((&accSum[39:31]) | ~(|accSum[39:31]));
  // super mode only clips on loss of bit 39; normal mode clips on guard overflow too
  assign clipEvent = carry39Lost | (~superSel & guardOverflow);
endmodule

// ---- hdl/cpu_status_core_control.v ----
// status word and core control word register bank with alu flag update
`timescale 1ns/1ps
`include "cpu_status_defs.vh"

module cpu_status_core_control (
  // clock and reset
  input wire clk,
  input wire nrst,
  input wire clkEn,
  // avalon-mm slave
  input wire [`ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [1:0] response,
  // alu request
  input wire aluValid,
  input wire [15:0] aluOpA,
  input wire [15:0] aluOpB,
  input wire [1:0] aluOp,
  input wire aluByte,
  input wire aluZeroSticky,
  output reg [15:0] aluResult,
  // accumulator adder
  input wire accAValid,
  input wire [39:0] accASum,
  input wire accACarryLost,
  input wire accBValid,
  input wire [39:0] accBSum,
  input wire accBCarryLost,
  // loop sequencer
  input wire doEnter,
  input wire doLeave,
  input wire repeatActive,
  output reg doEarlyExit,
  // external interrupt control
  input wire nestingDisable,
  // core configuration outputs
  output wire [3:0] cpuPriority,
  output wire userIrqDisable,
  output wire multUnsigned,
  output wire accAClipEnable,
  output wire accBClipEnable,
  output wire storeClipEnable,
  output wire superClipSelect,
  output wire programWindowEnable,
  output wire roundingSelect,
  output wire integerMultiply
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam BUS_IDLE = 1'b0;
  localparam BUS_DONE = 1'b1;

  reg busState_q;
  reg ovA_q;
  reg ovB_q;
  reg clA_q;
  reg clB_q;
  reg repeat_q;
  reg nib_q;
  reg [2:0] priLow_q;
  reg neg_q;
  reg sov_q;
  reg zero_q;
  reg carry_q;
  reg [2:0] depth_q;
  reg priTop_q;
  reg [7:0] ctlLow_q;
  reg uns_q;
  reg exitPend_q;

  wire [15:0] aluRes;
  wire aluC;
  wire aluDc;
  wire aluN;
  wire aluV;
  wire aluZ;
  wire [79:0] accSumAll;
  wire [1:0] accLostAll;
  wire [1:0] ovIn;
  wire [1:0] clIn;
  reg [15:0] readMux;
  wire [15:0] statusWord;
  wire [15:0] controlWord;
  wire hit;
  wire wrStatus;
  wire wrControl;
  wire wrLoop;
  wire [15:0] wd;
  wire [1:0] be;

  // ----------------------------------------------------------------
  // datapath helpers
  // ----------------------------------------------------------------
  mcu_alu alu (
    .opA(aluOpA),
    .opB(aluOpB),
    .opCode(aluOp),
    .byteMode(aluByte),
    .result(aluRes),
    .carry(aluC),
    .nibbleCarry(aluDc),
    .negative(aluN),
    .signFlip(aluV),
    .isZero(aluZ)
  );

  // one overflow detector per accumulator, index 0 is a and 1 is b
  assign accSumAll = {accBSum, accASum};
  assign accLostAll = {accBCarryLost, accACarryLost};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : accFlags
      acc_overflow ovf (
        .accSum(accSumAll[40*g+39:40*g]),
        .carry39Lost(accLostAll[g]),
        .superSel(ctlLow_q[`CC_SUPER]),
        .guardOverflow(ovIn[g]),
        .clipEvent(clIn[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  assign statusWord = {ovA_q, ovB_q, clA_q, clB_q,
                       ovA_q | ovB_q,
                       clA_q | clB_q,
                       (depth_q != 3'h0), nib_q, priLow_q, repeat_q,
                       neg_q, sov_q, zero_q, carry_q};
  // early exit always reads as zero
  assign controlWord = {3'h0, uns_q, 1'b0, depth_q,
                        ctlLow_q[7:4], priTop_q, ctlLow_q[2:0]};

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always @* begin
    case (address)
      `OFS_STATUS: begin
        readMux = statusWord;
      end
      `OFS_CONTROL: begin
        readMux = controlWord;
      end
      `OFS_LOOPCTL: begin
        readMux = {13'h0000, depth_q};
      end
      default: begin
        readMux = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & (busState_q == BUS_IDLE);
  assign hit = (address == `OFS_STATUS) | (address == `OFS_CONTROL) | (address == `OFS_LOOPCTL);
  assign wd = writedata[15:0];
  assign be = byteenable[1:0];
  assign wrStatus = clkEn & write & ~waitrequest & (address == `OFS_STATUS);
  assign wrControl = clkEn & write & ~waitrequest & (address == `OFS_CONTROL);
  assign wrLoop = clkEn & write & ~waitrequest & (address == `OFS_LOOPCTL);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busState_q <= BUS_IDLE;
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else if (clkEn) begin
      case (busState_q)
        BUS_IDLE: begin
          if (read | write) begin
            busState_q <= BUS_DONE;
            response <= hit ? 2'h0 : 2'h3;
            readdata <= read ? {16'h0000, readMux} : 32'h00000000;
          end
        end
        BUS_DONE: begin
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovA_q <= 1'b0;
      ovB_q <= 1'b0;
      clA_q <= 1'b0;
      clB_q <= 1'b0;
      repeat_q <= 1'b0;
      nib_q <= 1'b0;
      priLow_q <= 3'h0;
      neg_q <= 1'b0;
      sov_q <= 1'b0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      aluResult <= 16'h0000;
    end else if (clkEn) begin
      repeat_q <= repeatActive;
      // software writes first; hardware updates below override them
      if (wrStatus && be[1]) begin
        // clip flags are clear-only: writing 0 clears, writing 1 keeps; the nibble carry is loaded directly
        if (!wd[`ST_CLA]) clA_q <= 1'b0;
        if (!wd[`ST_CLB]) clB_q <= 1'b0;
        if (!wd[`ST_CLANY]) begin
          clA_q <= 1'b0;
          clB_q <= 1'b0;
        end
        nib_q <= wd[`ST_NIB];
      end
      if (wrStatus && be[0]) begin
        if (!nestingDisable) priLow_q <= wd[`ST_PRI_HI:`ST_PRI_LO];
        neg_q <= wd[`ST_NEG];
        sov_q <= wd[`ST_SOV];
        zero_q <= wd[`ST_ZERO];
        carry_q <= wd[`ST_CARRY];
      end
      if (accAValid) begin
        ovA_q <= ovIn[0];
        if (clIn[0]) clA_q <= 1'b1;
      end
      if (accBValid) begin
        ovB_q <= ovIn[1];
        if (clIn[1]) clB_q <= 1'b1;
      end
      if (aluValid) begin
        aluResult <= aluRes;
        nib_q <= aluDc;
        neg_q <= aluN;
        sov_q <= aluV;
        carry_q <= aluC;
        // sticky-zero ops can only clear, never set
        zero_q <= aluZeroSticky ? (zero_q & aluZ) : aluZ;
      end
    end
  end

  // ----------------------------------------------------------------
  // core control word and top priority bit
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uns_q <= 1'b0;
      ctlLow_q <= `CC_RESET_LOW;
      priTop_q <= 1'b0;
    end else if (clkEn) begin
      if (wrControl && be[1]) begin
        uns_q <= wd[`CC_UNS];
      end
      if (wrControl && be[0]) begin
        ctlLow_q <= wd[7:0];
        // top priority bit is clear-only through the control word; a loop control write loads it from bit 0
        if (!wd[`CC_PRITOP]) priTop_q <= 1'b0;
      end
      if (wrLoop && be[0]) begin
        priTop_q <= wd[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // do-loop nesting and early exit
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      depth_q <= 3'h0;
      exitPend_q <= 1'b0;
      doEarlyExit <= 1'b0;
    end else if (clkEn) begin
      // the exit request is only kept while a loop is open
      if (wrControl && be[1] && wd[`CC_EXIT]) begin
        exitPend_q <= 1'b1;
      end
      doEarlyExit <= exitPend_q & (depth_q != 3'h0) & ~doLeave;
      // enter and leave in the same cycle cancel out
      if (doEnter && !doLeave && depth_q != 3'h7) begin
        depth_q <= depth_q + 3'h1;
      end else if (doLeave && !doEnter && depth_q != 3'h0) begin
        depth_q <= depth_q - 3'h1;
        exitPend_q <= 1'b0;
      end else if (depth_q == 3'h0) begin
        exitPend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  assign cpuPriority = {priTop_q, priLow_q};
  assign userIrqDisable = priTop_q | (priLow_q == 3'h7);
  assign multUnsigned = uns_q;
  assign accAClipEnable = ctlLow_q[`CC_CLIPA];
  assign accBClipEnable = ctlLow_q[`CC_CLIPB];
  assign storeClipEnable = ctlLow_q[`CC_STCLIP];
  assign superClipSelect = ctlLow_q[`CC_SUPER];
  assign programWindowEnable = ctlLow_q[`CC_PROGWIN];
  assign roundingSelect = ctlLow_q[`CC_RND];
  assign integerMultiply = ctlLow_q[`CC_INTMUL];
endmodule

// ---- hdl/cpu_status_defs.vh ----
// register offsets, field positions and reset values of the status and control words
`ifndef CPU_STATUS_DEFS_VH
`define CPU_STATUS_DEFS_VH

// ----------------------------------------------------------------
// register map (word offsets on the avalon bus)
// ----------------------------------------------------------------
`define ADDR_W 2
`define OFS_STATUS 2'h0
`define OFS_CONTROL 2'h1
`define OFS_LOOPCTL 2'h2

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define ST_OVA 15
`define ST_OVB 14
`define ST_CLA 13
`define ST_CLB 12
`define ST_OVANY 11
`define ST_CLANY 10
`define ST_DOACT 9
`define ST_NIB 8
`define ST_PRI_HI 7
`define ST_PRI_LO 5
`define ST_RPTACT 4
`define ST_NEG 3
`define ST_SOV 2
`define ST_ZERO 1
`define ST_CARRY 0
`define ST_RESET 16'h0000

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define CC_UNS 12
`define CC_EXIT 11
`define CC_DEPTH_HI 10
`define CC_DEPTH_LO 8
`define CC_CLIPA 7
`define CC_CLIPB 6
`define CC_STCLIP 5
`define CC_SUPER 4
`define CC_PRITOP 3
`define CC_PROGWIN 2
`define CC_RND 1
`define CC_INTMUL 0
`define CC_RESET 16'h0020
`define CC_RESET_LOW 8'h20

// ----------------------------------------------------------------
// alu operation codes
// ----------------------------------------------------------------
`define OP_ADD 2'h0
`define OP_SUB 2'h1
`define OP_AND 2'h2
`define OP_SHL 2'h3
`endif

// ---- hdl/mcu_alu.v ----
// byte or word alu that forms result and flags for the status word
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
module mcu_alu (
  // operands
  input wire [15:0] opA,
  input wire [15:0] opB,
  input wire [1:0] opCode,
  input wire byteMode,
  // result and flags
  output reg [15:0] result,
  output reg carry,
  output reg nibbleCarry,
  output reg negative,
  output reg signFlip,
  output reg isZero
);
  reg [16:0] sum;
  reg [15:0] bOp;
  reg cin;
  reg [8:0] lowSum;
  reg [4:0] nibSum;
  reg msbA;
  reg msbB;
  reg msbR;

  always @* begin
    // subtraction adds the complement, so carry out means no borrow
    bOp = (opCode == `OP_SUB) ? ~opB : opB;
    cin = (opCode == `OP_SUB) ? 1'b1 : 1'b0;
    sum = {1'b0, opA} + {1'b0, bOp} + {16'h0000, cin};
    lowSum = {1'b0, opA[7:0]} + {1'b0, bOp[7:0]} + {8'h00, cin};
    nibSum = {1'b0, opA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
    result = 16'h0000;
    carry = 1'b0;
    nibbleCarry = 1'b0;
    case (opCode)
      `OP_ADD, `OP_SUB: begin
        result = sum[15:0];
        carry = byteMode ? lowSum[8] : sum[16];
        nibbleCarry = byteMode ? nibSum[4] : lowSum[8];
      end
      `OP_AND: begin
        result = opA & opB;
      end
      `OP_SHL: begin
        result = {opA[14:0], 1'b0};
        carry = byteMode ? opA[7] : opA[15];
      end
      default: begin
        result = 16'h0000;
      end
    endcase
    if (byteMode) begin
      result = {8'h00, result[7:0]};
    end
    msbA = byteMode ? opA[7] : opA[15];
    msbB = byteMode ? bOp[7] : bOp[15];
    msbR = byteMode ? result[7] : result[15];
    negative = msbR;
    signFlip = ((opCode == `OP_ADD) || (opCode == `OP_SUB)) && (msbA == msbB) && (msbR != msbA);
    isZero = (result == 16'h0000);
  end
endmodule

// ---- sim/cpu_status_core_control_tb_top.sv ----
// self-checking bench for the status and core control register bank
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
module cpu_status_core_control_tb_top;
  logic clk = '0, nrst = '0, read = '0, write = '0, aluValid = '0, aluByte = '0, aluZeroSticky = '0;
  logic accAValid = '0, accACarryLost = '0, accBValid = '0, accBCarryLost = '0, doEnter = '0, doLeave = '0;
  logic repeatActive = '0, nestingDisable = '0, clkEn = '1, pz;
  logic [1:0] address = '0, aluOp = '0, response, rsp;
  logic [31:0] writedata = '0, readdata;
  logic [15:0] aluOpA = '0, aluOpB = '0, aluResult, rv, mk;
  logic [39:0] accASum = '0, accBSum = '0;
  logic [3:0] cpuPriority;
  logic [20:0] e;
  logic waitrequest, doEarlyExit, userIrqDisable, multUnsigned, accAClipEnable, accBClipEnable, storeClipEnable;
  logic superClipSelect, programWindowEnable, roundingSelect, integerMultiply;
  int num_errors = 0, num_checks = 0;
  logic [15:0] tA [7] = '{16'h7fff, 16'hffff, 16'h000f, 16'h0080, 16'h0000, 16'h0005, 16'h0003};
  logic [15:0] tB [7] = '{16'h0001, 16'h0001, 16'h0001, 16'h0080, 16'h0001, 16'h0003, 16'h0003};
  logic [2:0] tM [7] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h4, 3'h5, 3'h5};
  logic [15:0] cv [3] = '{16'hffff, 16'h0000, 16'h10a5};
  wire [15:0] pri = {11'h000, userIrqDisable, cpuPriority};
  wire [15:0] cfgOut = {8'h00, multUnsigned, accAClipEnable, accBClipEnable, storeClipEnable, superClipSelect,
    programWindowEnable, roundingSelect, integerMultiply};

  cpu_status_core_control u_dut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .aluValid(aluValid), .aluOpA(aluOpA), .aluOpB(aluOpB), .aluOp(aluOp), .aluByte(aluByte),
    .aluZeroSticky(aluZeroSticky), .aluResult(aluResult), .accAValid(accAValid), .accASum(accASum),
    .accACarryLost(accACarryLost), .accBValid(accBValid), .accBSum(accBSum), .accBCarryLost(accBCarryLost),
    .doEnter(doEnter), .doLeave(doLeave), .repeatActive(repeatActive), .doEarlyExit(doEarlyExit),
    .nestingDisable(nestingDisable), .cpuPriority(cpuPriority), .userIrqDisable(userIrqDisable),
    .multUnsigned(multUnsigned), .accAClipEnable(accAClipEnable), .accBClipEnable(accBClipEnable),
    .storeClipEnable(storeClipEnable), .superClipSelect(superClipSelect), .programWindowEnable(programWindowEnable),
    .roundingSelect(roundingSelect), .integerMultiply(integerMultiply));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic waitAck();
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
  endtask

  task automatic busWrite(logic [1:0] a, logic [15:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {16'h0000, d};
    write <= 1'b1;
    waitAck();
    write <= 1'b0;
    @(negedge clk);
  endtask

  task automatic busRead(logic [1:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    waitAck();
    rv = readdata[15:0];
    rsp = response;
    read <= 1'b0;
  endtask

  task automatic rdChk(logic [1:0] a, logic [15:0] exp, logic [15:0] m, string nm);
    busRead(a);
    chk(nm, exp, rv & m);
  endtask

  task automatic aluRun(logic [15:0] a, logic [15:0] b, logic [2:0] m, logic [1:0] op);
    @(posedge clk);
    aluOpA <= a;
    aluOpB <= b;
    aluOp <= op;
    aluByte <= m[1];
    aluZeroSticky <= m[0];
    aluValid <= 1'b1;
    @(posedge clk);
    aluValid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic accPulse(logic b, logic [39:0] s, logic lost);
    @(posedge clk);
    accAValid <= !b;
    accBValid <= b;
    accASum <= s;
    accBSum <= s;
    accACarryLost <= lost;
    accBCarryLost <= lost;
    @(posedge clk);
    accAValid <= 1'b0;
    accBValid <= 1'b0;
  endtask

  task automatic loopStep(logic enter);
    @(posedge clk);
    doEnter <= enter;
    doLeave <= !enter;
    @(posedge clk);
    doEnter <= 1'b0;
    doLeave <= 1'b0;
  endtask

  // expected {result, nibble carry, negative, sign flip, zero, carry}
  function automatic logic [20:0] model(logic [15:0] a, logic [15:0] b, logic [2:0] m, logic pz);
    logic [15:0] bb;
    logic [16:0] s;
    logic [8:0] h;
    logic [4:0] q;
    logic c, dc, n, ov, z;
    bb = m[2] ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + m[2];
    h = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + m[2];
    q = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + m[2];
    c = m[1] ? h[8] : s[16];
    dc = m[1] ? q[4] : h[8];
    n = m[1] ? h[7] : s[15];
    ov = m[1] ? (a[7] == bb[7] && h[7] != a[7]) : (a[15] == bb[15] && s[15] != a[15]);
    z = m[1] ? (h[7:0] == 8'h00) : (s[15:0] == 16'h0000);
    return {s[15:0], dc, n, ov, m[0] ? (pz & z) : z, c};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #500000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdChk(`OFS_STATUS, 16'h0000, 16'hffff, "status reset");
    rdChk(`OFS_CONTROL, 16'h0020, 16'hffff, "control reset");
    busWrite(2'h3, 16'hffff);
    busRead(2'h3);
    chk("unmapped", 16'h0003, {14'h0000, rsp} | rv);
    rdChk(`OFS_CONTROL, 16'h0020, 16'hffff, "control kept");
    foreach (cv[i]) begin
      busWrite(`OFS_CONTROL, cv[i]);
      rdChk(`OFS_CONTROL, cv[i] & 16'h10f7, 16'hffff, "control");
      chk("config", {8'h00, cv[i][12], cv[i][7:4], cv[i][2:0]}, cfgOut);
    end
    pz = 1'b0;
    for (int i = 0; i < 7; i++) begin
      e = model(tA[i], tB[i], tM[i], pz);
      pz = e[1];
      aluRun(tA[i], tB[i], tM[i], tM[i][2] ? `OP_SUB : `OP_ADD);
      mk = tM[i][1] ? 16'h00ff : 16'hffff;
      chk("aluResult", e[20:5] & mk, aluResult & mk);
      rdChk(`OFS_STATUS, {7'h00, e[4], 4'h0, e[3:0]}, 16'h010f, "alu flags");
    end
    aluRun(16'hf0f0, 16'h3c3c, 3'h0, `OP_AND);
    chk("alu and", 16'h3030, aluResult);
    aluRun(16'h8001, 16'h0000, 3'h0, `OP_SHL);
    chk("alu shift", 16'h0002, aluResult);
    rdChk(`OFS_STATUS, 16'h0001, 16'h000f, "shift flags");
    busWrite(`OFS_CONTROL, 16'h0000);
    accPulse(1'b1, 40'h80_0000_0000, 1'b0);
    rdChk(`OFS_STATUS, 16'h5c00, 16'hfc00, "acc b overflow");
    accPulse(1'b1, 40'h00_0000_0000, 1'b0);
    rdChk(`OFS_STATUS, 16'h1400, 16'hfc00, "acc b sticky");
    busWrite(`OFS_STATUS, 16'h1000);
    rdChk(`OFS_STATUS, 16'h0000, 16'hfc00, "sticky cleared");
    busWrite(`OFS_STATUS, 16'hfe00);
    rdChk(`OFS_STATUS, 16'h0000, 16'hfe00, "no software set");
    // clip event lands on the same edge as a clearing status write
    fork
      busWrite(`OFS_STATUS, 16'h0000);
      begin
        @(posedge clk);
        accPulse(1'b0, 40'h01_0000_0000, 1'b1);
      end
    join
    rdChk(`OFS_STATUS, 16'hac00, 16'hfc00, "hw beats sw");
    busWrite(`OFS_STATUS, 16'h0000);
    busWrite(`OFS_CONTROL, 16'h0010);
    accPulse(1'b0, 40'h01_0000_0000, 1'b0);
    rdChk(`OFS_STATUS, 16'h8800, 16'hfc00, "super no clip");
    accPulse(1'b0, 40'h01_0000_0000, 1'b1);
    rdChk(`OFS_STATUS, 16'hac00, 16'hfc00, "carry lost clip");
    busWrite(`OFS_STATUS, 16'h00e0);
    chk("priority", 16'h0017, pri);
    busWrite(`OFS_STATUS, 16'h0040);
    chk("priority", 16'h0002, pri);
    @(posedge clk) nestingDisable <= 1'b1;
    busWrite(`OFS_STATUS, 16'h00e0);
    chk("priority", 16'h0002, pri);
    busWrite(`OFS_LOOPCTL, 16'h0001);
    chk("priority", 16'h001a, pri);
    rdChk(`OFS_CONTROL, 16'h0008, 16'h0008, "priority top");
    busWrite(`OFS_CONTROL, 16'h0000);
    chk("priority", 16'h0002, pri);
    repeat (7) loopStep(1'b1);
    rdChk(`OFS_CONTROL, 16'h0700, 16'h0f00, "depth seven");
    rdChk(`OFS_STATUS, 16'h0200, 16'h0200, "do active");
    busWrite(`OFS_CONTROL, 16'h0800);
    @(posedge clk);
    @(negedge clk);
    chk("early exit", 16'h0001, {15'h0000, doEarlyExit});
    rdChk(`OFS_CONTROL, 16'h0700, 16'h0f00, "exit reads zero");
    repeatActive <= 1'b1;
    repeat (7) loopStep(1'b0);
    rdChk(`OFS_STATUS, 16'h0010, 16'h0210, "loops idle");
    chk("early exit", 16'h0000, {15'h0000, doEarlyExit});
    clkEn <= 1'b0;
    accPulse(1'b1, 40'h80_0000_0000, 1'b1);
    clkEn <= 1'b1;
    rdChk(`OFS_STATUS, 16'h0000, 16'h5000, "frozen acc b");
    summarize();
  end
endmodule

// ---- sim/status_bank_chk.sv ----
// concurrent assertions on the bus and configuration ports of the status bank
`timescale 1ns/1ps
module status_bank_chk (
  // clock and reset
  input wire clk,
  input wire nrst,
  input wire clkEn,
  // bus
  input wire [1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire [1:0] response,
  // alu and configuration
  input wire aluValid,
  input wire [15:0] aluResult,
  input wire multUnsigned,
  input wire [3:0] cpuPriority,
  input wire userIrqDisable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rdDone = read && !waitrequest;
  wire ctlWr = write && !waitrequest && address == 2'h1;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_one_wait: assert property (clkEn && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait cycle");
  chk_ovany_or: assert property (rdDone && address == 2'h0 |-> readdata[11] == (readdata[15] | readdata[14]))
    else $error("combined overflow flag is not the or of both");
  chk_clany_or: assert property (rdDone && address == 2'h0 |-> readdata[10] == (readdata[13] | readdata[12]))
    else $error("combined clip flag is not the or of both");
  chk_exit_zero: assert property (rdDone && address == 2'h1 |-> !readdata[11])
    else $error("early exit bit read back as one");
  chk_unmapped_read: assert property (rdDone && address == 2'h3 |-> response == 2'h3 && readdata == 32'h0)
    else $error("unmapped read not refused");
  chk_irq_off: assert property (userIrqDisable == (cpuPriority[3] || cpuPriority[2:0] == 3'h7))
    else $error("user interrupt disable wrong for priority");
  chk_pri_read: assert property (rdDone && address == 2'h0 |-> readdata[7:5] == cpuPriority[2:0])
    else $error("priority low bits differ from status word");
  chk_mult_write: assert property ($changed(multUnsigned) |-> $past(ctlWr))
    else $error("multiply sign mode changed without control write");
  chk_result_cause: assert property ($changed(aluResult) |-> $past(aluValid))
    else $error("alu result changed without request");
  cover property (rdDone && address == 2'h3);
  cover property (userIrqDisable && cpuPriority[3]);
  cover property (aluValid);
endmodule

bind cpu_status_core_control status_bank_chk u_chk (.clk(clk), .nrst(nrst), .clkEn(clkEn), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .aluValid(aluValid), .aluResult(aluResult), .multUnsigned(multUnsigned), .cpuPriority(cpuPriority),
  .userIrqDisable(userIrqDisable));
